// [rtl/oelh_pkg.sv]
package oelh_pkg;
  localparam int OELH_N_SERVICE = 16;
  localparam int OELH_N_ENDPOINT = 16;
  localparam int OELH_N_PORT = 4;
  localparam int OELH_SIDX_W = 4;
  localparam int OELH_EP_W = 4;
  localparam int OELH_PORT_W = 2;
  localparam int OELH_CNT_W = 16;
  localparam logic [OELH_CNT_W-1:0] OELH_CNT_RST = 16'h0000;
  localparam logic [OELH_CNT_W-1:0] OELH_CNT_ONE = 16'h0001;
  localparam logic OELH_ENABLED = 1'b1;
  localparam int OELH_BUF_DEPTH = 2;

  typedef enum logic {
    OELH_STAGE_ANALYZER,
    OELH_STAGE_REWRITER
  } oelh_stage_e;

  // One frame presented to the lookup stage
  typedef struct packed {
    oelh_stage_e stage;
    logic [OELH_SIDX_W-1:0] service_index;
    logic egress_endpoint_select_valid;
    logic [OELH_EP_W-1:0] egress_endpoint_index;
    logic [OELH_PORT_W-1:0] port;
  } oelh_frame_s;

  // Lookup result leaving the stage
  typedef struct packed {
    logic processed;
    logic port_active;
    logic [OELH_EP_W-1:0] active_endpoint;
    logic active_up;
    logic rx_dir;
    logic server_counted;
    logic [OELH_EP_W-1:0] server_endpoint;
    logic port_counted;
  } oelh_result_s;

  localparam int OELH_FRAME_W = $bits(oelh_frame_s);
endpackage

// [rtl/oelh_buffer.sv]
module oelh_buffer
  import oelh_pkg::*;
#(
  parameter int WIDTH = OELH_FRAME_W,
  parameter int DEPTH = OELH_BUF_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW-1:0] wptr_inc = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
  wire [AW-1:0] rptr_inc = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;

  assign next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) wptr <= wptr_inc;
      if (pop) rptr <= rptr_inc;
      count <= next_count;
      // Ready is registered from the next fill level, so it leaves a flip-flop
      in_ready <= (next_count != (AW + 1)'(DEPTH));
    end
  end
endmodule

// [rtl/oelh_lookup.sv]
// Notes on behaviour
// - Up endpoint transmit lookup runs in analyzer on ingress frames.
// - Up endpoint receive lookup runs in rewriter on egress frames.
// - One up endpoint serves both its receive and transmit traffic.
// - Up endpoint transmits toward queues, receives from queues before front port.
// - Analyzer lookup uses per-service table; enable 1 supplies endpoint index.
// - Rewriter lookup uses egress action valid flag and endpoint index.
// - Unmapped frames go to the port endpoint; port lookup always happens.
// - Disabled port endpoint means no processing for fall-through frames.
// - Port endpoint active: only port endpoint counters increment.
// - Service frame counts at service, optional server, and port endpoint.
// - Three-layer hierarchy works in both analyzer and rewriter.
// - One lookup per stage; single active endpoint updates hierarchy counters.
// - Direction and facing follow stage per user/network traffic direction.
// - Active down service endpoint counts self, server, network port.
// - Down server active for own OAM counts self and network port.
// - Active up service endpoint counts self, up server, user port.
// - Up server active for own OAM counts only itself; code skips the port but still counts its server if one is enabled.
// - Flow may hit two up, two down endpoints and port: five levels.
// - Down endpoint receives in analyzer, transmits in rewriter.
module oelh_lookup
  import oelh_pkg::*;
#(
  parameter int N_SERVICE = OELH_N_SERVICE,
  parameter int N_ENDPOINT = OELH_N_ENDPOINT,
  parameter int N_PORT = OELH_N_PORT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire oelh_frame_s frame,
  input wire logic [N_SERVICE-1:0] ingress_endpoint_select_enable,
  input wire logic [N_SERVICE*OELH_EP_W-1:0] ingress_endpoint_index,
  input wire logic [N_ENDPOINT-1:0] endpoint_enable,
  input wire logic [N_ENDPOINT-1:0] endpoint_up,
  input wire logic [N_ENDPOINT-1:0] server_endpoint_enable,
  input wire logic [N_ENDPOINT*OELH_EP_W-1:0] server_endpoint_index,
  input wire logic [N_ENDPOINT-1:0] endpoint_is_server,
  input wire logic [N_PORT-1:0] port_endpoint_enable,
  input wire logic [OELH_EP_W-1:0] count_sel,
  input wire logic [OELH_PORT_W-1:0] port_count_sel,
  output logic result_valid,
  input wire logic result_ready,
  output oelh_result_s result,
  output logic [OELH_CNT_W-1:0] ep_rx_count,
  output logic [OELH_CNT_W-1:0] ep_tx_count,
  output logic [OELH_CNT_W-1:0] port_rx_count,
  output logic [OELH_CNT_W-1:0] port_tx_count
);
  function automatic logic [OELH_EP_W-1:0] pick_ep(
    input logic [N_ENDPOINT*OELH_EP_W-1:0] vec,
    input logic [OELH_EP_W-1:0] idx
  );
    pick_ep = vec[idx*OELH_EP_W +: OELH_EP_W];
  endfunction

  // Buffer in front of the lookup so a stalled result consumer drops nothing
  logic buf_valid;
  logic [OELH_FRAME_W-1:0] buf_data;
  oelh_frame_s cur;
  logic take;

  oelh_buffer #(.WIDTH(OELH_FRAME_W), .DEPTH(OELH_BUF_DEPTH)) u_buf (
    .mclk(mclk),
    .rst(rst),
    .in_valid(frame_valid),
    .in_ready(frame_ready),
    .in_data(frame),
    .out_valid(buf_valid),
    .out_ready(take),
    .out_data(buf_data)
  );
  assign cur = oelh_frame_s'(buf_data);

  // Output register accepts a new frame when empty or being drained
  assign take = buf_valid && (!result_valid || result_ready);

  wire in_ana = (cur.stage == OELH_STAGE_ANALYZER);
  wire [OELH_SIDX_W-1:0] sidx = cur.service_index;
  wire ana_hit = ingress_endpoint_select_enable[sidx] == OELH_ENABLED;
  wire [OELH_EP_W-1:0] ana_ep = ingress_endpoint_index[sidx*OELH_EP_W +: OELH_EP_W];
  wire rew_hit = cur.egress_endpoint_select_valid == OELH_ENABLED;
  wire svc_hit = in_ana ? ana_hit : rew_hit;
  wire [OELH_EP_W-1:0] svc_ep = in_ana ? ana_ep : cur.egress_endpoint_index;
  wire svc_on = svc_hit && endpoint_enable[svc_ep];
  wire port_on = port_endpoint_enable[cur.port];
  // Fall-through to the port endpoint cannot be suppressed
  wire port_path = !svc_hit;
  wire processed = svc_hit ? svc_on : port_on;
  wire svc_up = endpoint_up[svc_ep];
  // Up: analyzer is transmit, rewriter is receive; down is the reverse
  wire rx_dir = svc_hit && svc_up ? !in_ana : in_ana;
  wire srv_en = server_endpoint_enable[svc_ep] == OELH_ENABLED;
  wire [OELH_EP_W-1:0] srv_ep = pick_ep(server_endpoint_index, svc_ep);
  // Server counting needs the target flagged as server and enabled
  wire srv_cnt = svc_on && srv_en && endpoint_is_server[srv_ep] && endpoint_enable[srv_ep];
  // Up server handling its own OAM never passes the user port
  wire up_srv_self = svc_on && svc_up && endpoint_is_server[svc_ep];
  wire port_cnt = port_path ? port_on : (svc_on && !up_srv_self);
  wire do_cnt = take && processed;

  oelh_result_s next_result;
  always_comb begin
    next_result.processed = processed;
    next_result.port_active = port_path;
    next_result.active_endpoint = svc_ep;
    next_result.active_up = svc_hit && svc_up;
    next_result.rx_dir = rx_dir;
    next_result.server_counted = srv_cnt;
    next_result.server_endpoint = srv_ep;
    next_result.port_counted = port_cnt;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
      result <= '0;
    end else if (take) begin
      result_valid <= 1'b1;
      result <= next_result;
    end else if (result_ready) begin
      result_valid <= 1'b0;
    end
  end

  // Loss counters: every layer updated in the same cycle as the lookup
  logic [OELH_CNT_W-1:0] ep_rx [N_ENDPOINT];
  logic [OELH_CNT_W-1:0] ep_tx [N_ENDPOINT];
  logic [OELH_CNT_W-1:0] pt_rx [N_PORT];
  logic [OELH_CNT_W-1:0] pt_tx [N_PORT];

  genvar g;
  generate
    for (g = 0; g < N_ENDPOINT; g++) begin : g_ep
      wire hit_svc = do_cnt && !port_path && (svc_ep == OELH_EP_W'(g));
      wire hit_srv = do_cnt && srv_cnt && (srv_ep == OELH_EP_W'(g));
      wire [1:0] n = {1'b0, hit_svc} + {1'b0, hit_srv};
      wire [OELH_CNT_W-1:0] inc = OELH_CNT_W'(n);
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          ep_rx[g] <= OELH_CNT_RST;
          ep_tx[g] <= OELH_CNT_RST;
        end else if (rx_dir) begin
          ep_rx[g] <= ep_rx[g] + inc;
        end else begin
          ep_tx[g] <= ep_tx[g] + inc;
        end
      end
    end
    for (g = 0; g < N_PORT; g++) begin : g_pt
      wire hit = do_cnt && port_cnt && (cur.port == OELH_PORT_W'(g));
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          pt_rx[g] <= OELH_CNT_RST;
          pt_tx[g] <= OELH_CNT_RST;
        end else if (hit && rx_dir) begin
          pt_rx[g] <= pt_rx[g] + OELH_CNT_ONE;
        end else if (hit) begin
          pt_tx[g] <= pt_tx[g] + OELH_CNT_ONE;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ep_rx_count <= OELH_CNT_RST;
      ep_tx_count <= OELH_CNT_RST;
      port_rx_count <= OELH_CNT_RST;
      port_tx_count <= OELH_CNT_RST;
    end else begin
      ep_rx_count <= ep_rx[count_sel];
      ep_tx_count <= ep_tx[count_sel];
      port_rx_count <= pt_rx[port_count_sel];
      port_tx_count <= pt_tx[port_count_sel];
    end
  end
endmodule

// [tb/oelh_sink.sv]
module oelh_sink
  import oelh_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  output logic result_ready
);
  logic [1:0] phase;
  // Slow mode takes one result in four so the buffer backs up
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase <= 2'h0;
      result_ready <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      result_ready <= !slow || (phase == 2'h3);
    end
  end
endmodule

// [tb/oelh_lookup_sva.sv]
module oelh_lookup_sva
  import oelh_pkg::*;
#(parameter int N_ENDPOINT = OELH_N_ENDPOINT) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic result_valid,
  input wire logic result_ready,
  input wire oelh_result_s result,
  input wire logic [N_ENDPOINT*OELH_EP_W-1:0] server_endpoint_index,
  input wire logic [N_ENDPOINT-1:0] endpoint_is_server
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic v, svc, up_srv;
  assign v = result_valid && result.processed;
  assign svc = v && !result.port_active;
  assign up_srv = svc && result.active_up && endpoint_is_server[result.active_endpoint];
  hold_result_a: assert property (
    result_valid && !result_ready |=> result_valid && $stable(result)) else $error("result moved");
  idle_count_a: assert property (
    result_valid && !result.processed |-> !(result.port_counted || result.server_counted))
    else $error("idle frame counted");
  port_only_a: assert property (
    v && result.port_active |-> result.port_counted && !result.server_counted)
    else $error("port hit wrong layers");
  server_index_a: assert property (
    v && result.server_counted |->
    result.server_endpoint == server_endpoint_index[result.active_endpoint*OELH_EP_W +: OELH_EP_W])
    else $error("wrong server");
  server_flag_a: assert property (
    v && result.server_counted |-> endpoint_is_server[result.server_endpoint])
    else $error("server flag off");
  down_port_a: assert property (
    svc && !result.active_up |-> result.port_counted) else $error("down port missed");
  up_client_a: assert property (
    svc && result.active_up && !up_srv |-> result.port_counted) else $error("up port missed");
  up_server_a: assert property (
    up_srv |-> !result.port_counted) else $error("up server hit port");
  cover property (svc && result.server_counted);
  cover property (result_valid && !result_ready);
  cover property (v && result.port_active);
endmodule

bind oelh_lookup oelh_lookup_sva #(.N_ENDPOINT(N_ENDPOINT)) i_oelh_lookup_sva (.*);

// [tb/testbench.sv]
module testbench
  import oelh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam oelh_stage_e AN = OELH_STAGE_ANALYZER;
  localparam oelh_stage_e RW = OELH_STAGE_REWRITER;
  logic mclk = 1'b0, rst = 1'b1, frame_valid = 1'b0, slow = 1'b0, refused = 1'b0;
  logic frame_ready, result_valid, result_ready;
  logic [15:0] ep_rx_count, ep_tx_count, port_rx_count, port_tx_count;
  logic [15:0] ingress_endpoint_select_enable = '0, endpoint_enable = '0, endpoint_up = '0;
  logic [15:0] server_endpoint_enable = '0, endpoint_is_server = '0;
  logic [63:0] ingress_endpoint_index = '0, server_endpoint_index = '0;
  logic [3:0] port_endpoint_enable = '0, count_sel = '0;
  logic [1:0] port_count_sel = '0;
  oelh_frame_s frame = '0;
  oelh_result_s result;
  oelh_result_s rq[$];
  int n_fail = 0, num_checks = 0;
  always #50 mclk = ~mclk;
  oelh_lookup i_oelh_lookup (.*);
  oelh_sink i_oelh_sink (.*);
  always @(negedge mclk) begin
    if (result_valid === 1'b1 && result_ready === 1'b1) rq.push_back(result);
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic oelh_frame_s fr(oelh_stage_e s, logic [3:0] si, logic v, logic [3:0] ei,
                                     logic [1:0] p);
    return '{s, si, v, ei, p};
  endfunction
  // Flags: port active, up, receive side, server counted, port counted
  function automatic oelh_result_s rs(logic [4:0] f, logic [3:0] ae, logic [3:0] se);
    return '{1'b1, f[4], ae, f[3], f[2], f[1], se, f[0]};
  endfunction
  task automatic push(input oelh_frame_s f);
    logic ok;
    ok = 1'b0;
    frame <= f;
    frame_valid <= 1'b1;
    for (int i = 0; i < 60 && ok !== 1'b1; i++) begin
      @(negedge mclk) ok = frame_ready;
      refused |= (ok !== 1'b1);
      @(posedge mclk);
    end
    if (ok !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
  endtask
  task automatic get(input oelh_result_s e);
    oelh_result_s g;
    @(posedge mclk);
    for (int i = 0; i < 80 && rq.size() == 0; i++) @(posedge mclk);
    if (rq.size() == 0) begin
      n_fail++;
      tally_and_finish();
    end
    g = rq.pop_front();
    // Fields without meaning for this outcome are not judged
    if (!e.server_counted) g.server_endpoint = e.server_endpoint;
    if (e.port_active || !e.processed) {g.active_endpoint, g.active_up} = {e.active_endpoint, e.active_up};
    if (!e.processed) {g.port_active, g.rx_dir} = {e.port_active, e.rx_dir};
    chk("result", 64'(e), 64'(g));
  endtask
  task automatic go(input oelh_frame_s f, input oelh_result_s e);
    push(f);
    frame_valid <= 1'b0;
    get(e);
  endtask
  task automatic cnt(input logic [3:0] ep, input logic [1:0] p, input logic [63:0] e);
    count_sel <= ep;
    port_count_sel <= p;
    repeat (3) @(posedge mclk);
    @(negedge mclk) chk("counts", e, {ep_rx_count, ep_tx_count, port_rx_count, port_tx_count});
    @(posedge mclk);
  endtask
  task automatic t_port();
    go(fr(AN, 4'h0, 1'b0, 4'h0, 2'h2), rs(5'b10101, 4'h0, 4'h0));
    go(fr(RW, 4'h0, 1'b0, 4'h0, 2'h2), rs(5'b10001, 4'h0, 4'h0));
    go(fr(AN, 4'h0, 1'b0, 4'h0, 2'h1), '0);
    cnt(4'h0, 2'h2, 64'h0000_0000_0001_0001);
    cnt(4'h0, 2'h1, 64'h0);
    $display("test port done");
  endtask
  task automatic t_down();
    go(fr(AN, 4'h3, 1'b0, 4'h0, 2'h0), rs(5'b00111, 4'h5, 4'h7));
    go(fr(RW, 4'h0, 1'b1, 4'h5, 2'h0), rs(5'b00011, 4'h5, 4'h7));
    go(fr(AN, 4'h4, 1'b0, 4'h0, 2'h0), rs(5'b00101, 4'h7, 4'h0));
    go(fr(RW, 4'h0, 1'b1, 4'h1, 2'h0), '0);
    cnt(4'h5, 2'h0, 64'h0001_0001_0002_0001);
    cnt(4'h7, 2'h0, 64'h0002_0001_0002_0001);
    $display("test down done");
  endtask
  task automatic t_up();
    go(fr(AN, 4'h6, 1'b0, 4'h0, 2'h3), rs(5'b01011, 4'h9, 4'ha));
    go(fr(RW, 4'h0, 1'b1, 4'h9, 2'h3), rs(5'b01111, 4'h9, 4'ha));
    go(fr(RW, 4'h0, 1'b1, 4'ha, 2'h3), rs(5'b01100, 4'ha, 4'h0));
    cnt(4'h9, 2'h3, 64'h0001_0001_0001_0001);
    cnt(4'ha, 2'h3, 64'h0002_0001_0001_0001);
    $display("test up done");
  endtask
  task automatic t_burst();
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) push(fr(RW, 4'h0, 1'b0, 4'h0, 2'h2));
    frame_valid <= 1'b0;
    for (int i = 0; i < 4; i++) get(rs(5'b10001, 4'h0, 4'h0));
    slow <= 1'b0;
    chk("refused", 64'h1, 64'(refused));
    cnt(4'h0, 2'h2, 64'h0000_0000_0001_0005);
    $display("test burst done");
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    ingress_endpoint_select_enable <= 16'h0058;
    ingress_endpoint_index <= 64'h0000_0000_0907_5000;
    endpoint_enable <= 16'h06a0;
    endpoint_up <= 16'h0600;
    server_endpoint_enable <= 16'h0220;
    server_endpoint_index <= 64'h0000_00a0_0070_0000;
    endpoint_is_server <= 16'h0480;
    // Port 1 stays off so fall-through frames there go unprocessed
    port_endpoint_enable <= 4'hd;
    @(posedge mclk);
    chk("idle", 64'h0, 64'(result_valid));
    cnt(4'h0, 2'h0, 64'h0);
    t_port();
    t_down();
    t_up();
    t_burst();
    tally_and_finish();
  end
endmodule
